// >>> scs_conv_seq.sv
// Purpose: sequences start, settling delay, sampling and overhead of conversions
// Assumes: start pin and start command pulse are synchronous to clk
// Notes: startCmd pulses at the seventh falling serial clock edge of a start command
//
// Overview of operation
// RULE_01: sinc filter drops first two results
// RULE_02: first sinc result takes tabulated period count
// RULE_03: later continuous results follow every data period
// RULE_04: start on pin rise or start command
// RULE_05: three-bit code picks settling delay length
// RULE_06: default delay 14, modulator period 16 clocks
// RULE_07: delay only before first continuous conversion
// RULE_08: first conversion is delay, sampling, overhead
// RULE_09: overhead applies compensation before result shown
// RULE_10: suppressed results skip overhead, never readable
// RULE_11: same phase sequence for both filters
// RULE_12: all timing counted in modulator periods
// RULE_13: 60 SPS sinc gives 12857 then 4264
// RULE_14: filter select low picks sinc filter
// RULE_15: start while busy restarts whole sequence
module scs_conv_seq
  import scs_pkg::*;
#(
  parameter int MOD_DIV = scs_pkg::SCS_MOD_DIV,
  parameter int CNT_W = scs_pkg::SCS_CNT_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic convClkTick,
  input wire logic startPin,
  input wire logic startCmd,
  input wire logic stopCmd,
  input wire logic contMode,
  input wire logic filterSel,
  input wire logic [3:0] rateSel,
  input wire logic [2:0] delaySel,
  output logic busy,
  output logic sampleEn,
  output logic compEn,
  output logic discardPulse,
  output logic resultValid
);
  import scs_pkg::*;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  initial begin
    if (CNT_W != 20) begin
      $error("scs_conv_seq: CNT_W must be 20 to hold the phase tables");
    end
    if (MOD_DIV < 2) begin
      $error("scs_conv_seq: MOD_DIV must be at least 2");
    end
  end

  // ----------------------------------------------------------------
  // modulator period tick
  // ----------------------------------------------------------------
  logic modTick;

  scs_tick_div #(.DIV(MOD_DIV)) u_mod_div ( // RULE_06 RULE_12
    .clk(clk),
    .srst(srst),
    .clkEn(clkEn),
    .inTick(convClkTick),
    .outTick(modTick)
  );

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  scs_state_e state_ff, nxt_state;
  logic [CNT_W-1:0] phaseCnt_ff, nxt_phaseCnt;
  logic [1:0] convIdx_ff, nxt_convIdx;
  logic first_ff, nxt_first;
  logic cont_ff, nxt_cont;
  logic sinc_ff, nxt_sinc;
  logic [3:0] rate_ff, nxt_rate;
  logic [2:0] delay_ff, nxt_delay;
  logic pinPrev_ff;
  logic resultValid_ff, nxt_resultValid;
  logic discard_ff, nxt_discard;
  logic startReq;
  logic [3:0] rateIdx;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] ovh;
  logic [1:0] needed;

  // start detection and per-conversion lengths
  always_comb begin
    startReq = (startPin & ~pinPrev_ff) | startCmd; // RULE_04
    rateIdx = (rate_ff > SCS_LAST_RATE) ? SCS_LAST_RATE : rate_ff;
    period = SCS_PERIOD[rateIdx]; // RULE_03
    ovh = (rateIdx <= SCS_LAST_SLOW_RATE) ? SCS_OVH_SLOW : SCS_OVH_FAST;
    needed = sinc_ff ? SCS_SETTLE_SINC : SCS_SETTLE_LOWLAT; // RULE_11
  end

  // next state of the phase sequence
  always_comb begin
    nxt_state = state_ff;
    nxt_phaseCnt = phaseCnt_ff;
    nxt_convIdx = convIdx_ff;
    nxt_first = first_ff;
    nxt_cont = cont_ff;
    nxt_sinc = sinc_ff;
    nxt_rate = rate_ff;
    nxt_delay = delay_ff;
    nxt_resultValid = 1'b0;
    nxt_discard = 1'b0;
    if (startReq) begin
      // any start, busy or not, restarts from the settling delay
      nxt_state = SCS_DELAYING; // RULE_15
      nxt_phaseCnt = SCS_DELAY[delaySel]; // RULE_05
      nxt_convIdx = 2'h0;
      nxt_first = 1'b1;
      nxt_cont = contMode;
      nxt_sinc = ~filterSel; // RULE_14
      nxt_rate = rateSel;
      nxt_delay = delaySel;
    end else if (stopCmd) begin
      nxt_state = SCS_IDLE;
    end else if (modTick && state_ff != SCS_IDLE) begin
      if (phaseCnt_ff == 20'h00001) begin
        case (state_ff)
          SCS_DELAYING: begin
            nxt_state = SCS_SAMPLING; // RULE_08
            nxt_phaseCnt = period;
          end
          SCS_SAMPLING: begin
            if (first_ff && (2'(convIdx_ff + 2'h1) < needed)) begin
              // unsettled sinc data: no overhead, nothing presented
              nxt_convIdx = 2'(convIdx_ff + 2'h1); // RULE_01
              nxt_discard = 1'b1; // RULE_10
              nxt_phaseCnt = period;
            end else begin
              nxt_state = SCS_OVERHEAD; // RULE_09
              nxt_phaseCnt = ovh;
            end
          end
          SCS_OVERHEAD: begin
            nxt_resultValid = 1'b1; // RULE_02 RULE_13
            nxt_first = 1'b0;
            if (cont_ff) begin
              // later conversions skip the delay and keep the data period
              nxt_state = SCS_SAMPLING; // RULE_07
              nxt_phaseCnt = CNT_W'(period - ovh); // RULE_03
            end else begin
              nxt_state = SCS_IDLE;
            end
          end
          default: begin
            nxt_state = SCS_IDLE;
          end
        endcase
      end else begin
        nxt_phaseCnt = CNT_W'(phaseCnt_ff - 1'b1); // RULE_12
      end
    end
  end

  // sequencer registers, frozen while clkEn is low
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= SCS_IDLE;
      phaseCnt_ff <= '0;
      convIdx_ff <= 2'h0;
      first_ff <= 1'b0;
      cont_ff <= 1'b0;
      sinc_ff <= 1'b1;
      rate_ff <= 4'h0;
      delay_ff <= SCS_DELAY_RST;
      pinPrev_ff <= 1'b0;
      resultValid_ff <= 1'b0;
      discard_ff <= 1'b0;
    end else if (clkEn) begin
      state_ff <= nxt_state;
      phaseCnt_ff <= nxt_phaseCnt;
      convIdx_ff <= nxt_convIdx;
      first_ff <= nxt_first;
      cont_ff <= nxt_cont;
      sinc_ff <= nxt_sinc;
      rate_ff <= nxt_rate;
      delay_ff <= nxt_delay;
      pinPrev_ff <= startPin;
      resultValid_ff <= nxt_resultValid;
      discard_ff <= nxt_discard;
    end
  end

  // status outputs
  assign busy = (state_ff != SCS_IDLE);
  assign sampleEn = (state_ff == SCS_SAMPLING);
  assign compEn = (state_ff == SCS_OVERHEAD);
  assign discardPulse = discard_ff;
  assign resultValid = resultValid_ff;

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] ticksSince_ff;
  logic [1:0] discards_ff;
  logic [CNT_W-1:0] expFirst;

  // modulator ticks and dropped results since the last start or result
  always_ff @(posedge clk) begin
    if (srst) begin
      ticksSince_ff <= '0;
      discards_ff <= 2'h0;
    end else if (clkEn) begin
      if (startReq) begin
        ticksSince_ff <= '0;
        discards_ff <= 2'h0;
      end else if (resultValid_ff) begin
        ticksSince_ff <= modTick ? CNT_W'(1) : '0;
        discards_ff <= 2'h0;
      end else begin
        if (modTick) begin
          ticksSince_ff <= CNT_W'(ticksSince_ff + 1'b1);
        end
        if (discard_ff) begin
          discards_ff <= 2'(discards_ff + 2'h1);
        end
      end
    end
  end

  assign expFirst = CNT_W'(SCS_DELAY[delay_ff] + ovh + (sinc_ff ? CNT_W'(3 * period) : period));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_start;
    clkEn && startReq;
  endsequence

  sequence s_delay_entered;
    state_ff == SCS_DELAYING && !sampleEn;
  endsequence

  property p_start_restarts;
    @(posedge clk) disable iff (srst) s_start |=> s_delay_entered;
  endproperty
  a_start_restarts: assert property (p_start_restarts) else $error("start did not enter delay"); // RULE_04 RULE_15

  // a result held through a frozen cycle is not a fresh one, so the enable of the last cycle is part of the trigger
  property p_first_time;
    @(posedge clk) disable iff (srst) ($past(clkEn) && resultValid_ff && $past(first_ff))
      |-> ticksSince_ff == expFirst;
  endproperty
  a_first_time: assert property (p_first_time) else $error("first result at wrong time"); // RULE_02 RULE_13

  property p_next_time;
    @(posedge clk) disable iff (srst) ($past(clkEn) && resultValid_ff && !$past(first_ff))
      |-> ticksSince_ff == period;
  endproperty
  a_next_time: assert property (p_next_time) else $error("later result off data period"); // RULE_03 RULE_07

  property p_two_dropped;
    @(posedge clk) disable iff (srst) ($past(clkEn) && resultValid_ff && $past(first_ff))
      |-> discards_ff == (sinc_ff ? 2'h2 : 2'h0);
  endproperty
  a_two_dropped: assert property (p_two_dropped) else $error("wrong count of dropped results"); // RULE_01 RULE_11

  property p_overhead_first;
    @(posedge clk) disable iff (srst) ($past(clkEn) && resultValid_ff) |-> $past(state_ff) == SCS_OVERHEAD;
  endproperty
  a_overhead_first: assert property (p_overhead_first) else $error("result without overhead"); // RULE_08 RULE_09

  property p_drop_no_overhead;
    @(posedge clk) disable iff (srst) discard_ff |-> !resultValid_ff && state_ff == SCS_SAMPLING;
  endproperty
  a_drop_no_overhead: assert property (p_drop_no_overhead) else $error("dropped result took overhead"); // RULE_10

  property p_mod_period;
    @(posedge clk) disable iff (srst) modTick |-> convClkTick && clkEn;
  endproperty
  a_mod_period: assert property (p_mod_period) else $error("modulator tick without clock tick"); // RULE_06 RULE_12

  property p_filter_sel;
    @(posedge clk) disable iff (srst) s_start |=> sinc_ff == !$past(filterSel);
  endproperty
  a_filter_sel: assert property (p_filter_sel) else $error("filter select decoded wrongly"); // RULE_14

  property p_delay_load;
    @(posedge clk) disable iff (srst) s_start |=> phaseCnt_ff == SCS_DELAY[$past(delaySel)];
  endproperty
  a_delay_load: assert property (p_delay_load) else $error("delay length not loaded"); // RULE_05

endmodule // scs_conv_seq

// >>> scs_host_model.sv
// Purpose: host side model giving start triggers, stop pulses and converter ticks
// Assumes: the bench raises one request at a time, each for one cycle
// Notes: slowTick halves the converter clock rate to show proportional timing
module scs_host_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic reqPin,
  input wire logic reqCmd,
  input wire logic reqStop,
  input wire logic slowTick,
  output logic startPin,
  output logic startCmd,
  output logic stopCmd,
  output logic convClkTick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pinCnt_ff;
  logic tickPh_ff;
  // pin stays high three cycles; command pulse marks the seventh falling serial clock edge
  always_ff @(posedge clk) begin
    if (srst) begin
      pinCnt_ff <= 2'h0;
      startCmd <= 1'h0;
      stopCmd <= 1'h0;
      tickPh_ff <= 1'h0;
    end else begin
      pinCnt_ff <= reqPin ? 2'h3 : pinCnt_ff - {1'h0, pinCnt_ff != 2'h0};
      startCmd <= reqCmd;
      stopCmd <= reqStop;
      tickPh_ff <= ~tickPh_ff;
    end
  end
  assign startPin = pinCnt_ff != 2'h0;
  // converter ticks every cycle, or every other cycle when slow
  assign convClkTick = slowTick ? tickPh_ff : 1'h1;
endmodule // scs_host_model

// >>> scs_pkg.sv
// Purpose: shared constants and types for the sinc3 conversion sequencer
// Assumes: all phase lengths are counted in modulator periods
// Notes: data rate codes 0..13 run from 2.5 SPS up to 4000 SPS
package scs_pkg;

  // ----------------------------------------------------------------
  // widths and dividers
  // ----------------------------------------------------------------
  localparam int SCS_CNT_W = 20;
  localparam int SCS_MOD_DIV = 16; // converter clocks per modulator_period
  localparam int SCS_NUM_RATES = 14;

  // ----------------------------------------------------------------
  // phase lengths in modulator periods
  // ----------------------------------------------------------------
  // normal data period per rate code, 2.5 SPS first
  localparam logic [19:0] SCS_PERIOD [SCS_NUM_RATES] = '{
    20'h19000, 20'h0c800, 20'h06400, 20'h03c00, 20'h03200, 20'h01400, 20'h010a8,
    20'h00a00, 20'h00500, 20'h00280, 20'h00140, 20'h00100, 20'h00080, 20'h00040};
  // overhead: 65 periods up to 800 SPS, 40 periods from 1000 SPS
  localparam logic [19:0] SCS_OVH_SLOW = 20'h00041;
  localparam logic [19:0] SCS_OVH_FAST = 20'h00028;
  localparam logic [3:0] SCS_LAST_SLOW_RATE = 4'ha;
  localparam logic [3:0] SCS_LAST_RATE = 4'hd;
  // settling delay per delay code, code 0 is the default 14 periods
  localparam logic [19:0] SCS_DELAY [8] = '{
    20'h0000e, 20'h0001c, 20'h00038, 20'h00070, 20'h000e0, 20'h001c0, 20'h00380, 20'h00700};
  localparam logic [2:0] SCS_DELAY_RST = 3'h0;

  // ----------------------------------------------------------------
  // settled result counts and states
  // ----------------------------------------------------------------
  localparam logic [1:0] SCS_SETTLE_SINC = 2'h3;
  localparam logic [1:0] SCS_SETTLE_LOWLAT = 2'h1;

  typedef enum logic [1:0] {SCS_IDLE, SCS_DELAYING, SCS_SAMPLING, SCS_OVERHEAD} scs_state_e;

endpackage

// >>> scs_tick_div.sv
// Purpose: divides converter clock ticks into modulator period ticks
// Assumes: inTick is a one-cycle pulse per converter clock
// Notes: outTick is combinational and lasts one clk cycle
module scs_tick_div #(
  parameter int DIV = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic inTick,
  output logic outTick
);

  localparam int W = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  initial begin
    if (DIV < 2) begin
      $error("scs_tick_div: DIV must be at least 2");
    end
  end

  logic [W-1:0] div_ff;
  logic [W-1:0] nxt_div;

  // prescaler next value, wraps after DIV input ticks
  always_comb begin
    nxt_div = div_ff;
    if (inTick) begin
      nxt_div = (div_ff == LAST) ? '0 : W'(div_ff + 1'b1);
    end
  end

  // prescaler register
  always_ff @(posedge clk) begin
    if (srst) begin
      div_ff <= '0;
    end else if (clkEn) begin
      div_ff <= nxt_div;
    end
  end

  assign outTick = clkEn & inTick & (div_ff == LAST);

endmodule // scs_tick_div

// >>> tb_top.sv
// Purpose: self-checking bench for the conversion sequencer
// Assumes: the host model supplies start triggers and converter ticks
// Notes: random configurations come from a fixed-seed lfsr
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scs_pkg::*;
  logic clk = 1'h0, srst = 1'h1, clkEn = 1'h1, contMode = 1'h0, filterSel = 1'h0;
  logic reqPin = 1'h0, reqCmd = 1'h0, reqStop = 1'h0, slowTick = 1'h0, pinPrev = 1'h0;
  logic [3:0] rateSel = 4'hd;
  logic [2:0] delaySel = 3'h0;
  logic startPin, startCmd, stopCmd, convClkTick, busy, sampleEn, compEn, discardPulse, resultValid;
  logic [31:0] seed = 32'h6c175a23;
  int errors = 0, checked = 0, cyc = 0, startCyc = 0, compCyc = 0, sampCyc = 0;
  always #4 clk = ~clk;
  scs_host_model u_scs_host_model (.clk(clk), .srst(srst), .reqPin(reqPin), .reqCmd(reqCmd),
    .reqStop(reqStop), .slowTick(slowTick), .startPin(startPin), .startCmd(startCmd),
    .stopCmd(stopCmd), .convClkTick(convClkTick));
  scs_conv_seq u_scs_conv_seq (.clk(clk), .srst(srst), .clkEn(clkEn), .convClkTick(convClkTick),
    .startPin(startPin), .startCmd(startCmd), .stopCmd(stopCmd), .contMode(contMode),
    .filterSel(filterSel), .rateSel(rateSel), .delaySel(delaySel), .busy(busy), .sampleEn(sampleEn),
    .compEn(compEn), .discardPulse(discardPulse), .resultValid(resultValid));
  // notes the cycle of the latest start and of the latest overhead phase
  always @(posedge clk) begin
    cyc++;
    if (startCmd || (startPin && !pinPrev)) startCyc = cyc;
    if (sampleEn && sampCyc <= startCyc) sampCyc = cyc; // first sampling cycle after the latest start
    if (compEn) compCyc = cyc;
    pinPrev = startPin;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // modulator periods to first result: delay, sampling runs, overhead
  function automatic int exp_ticks(input logic filt, input logic [3:0] r, input logic [2:0] d);
    return SCS_DELAY[d] + (filt ? 1 : 3) * SCS_PERIOD[r] + (r > 4'ha ? 40 : 65);
  endfunction
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one conversion run; frz freezes clkEn, rst restarts after that many cycles
  task automatic conv(input logic viaPin, input logic cnt, input logic filt, input logic [3:0] rate,
                      input logic [2:0] dly, input int frz, input int rst);
    int tp, n, drops, i, first, ds;
    logic [3:0] rc;
    rc = (rate > SCS_LAST_RATE) ? SCS_LAST_RATE : rate; // codes above the last act as the last
    tp = slowTick ? 32 : 16;
    n = exp_ticks(filt, rc, dly) * tp + frz;
    ds = SCS_DELAY[dly] * tp + frz;
    drops = 0;
    i = 0;
    contMode = cnt;
    filterSel = filt;
    rateSel = rate;
    delaySel = dly;
    if (viaPin) reqPin = 1'h1;
    else reqCmd = 1'h1;
    tick;
    reqPin = 1'h0;
    reqCmd = 1'h0;
    while (resultValid !== 1'h1 && i < n + rst + 200) begin
      tick;
      i++;
      drops += (discardPulse === 1'h1);
      if (i == rst) reqCmd = 1'h1;
      if (i == rst + 1) begin
        reqCmd = 1'h0;
        drops = 0;
      end
      clkEn = !(frz > 0 && i >= 150 && i < 150 + frz);
    end
    `CHK(drops, filt ? 0 : 2)
    `CHK((cyc - startCyc > n - tp) && (cyc - startCyc <= n + 3), 1'h1)
    `CHK(cyc - compCyc <= 2 && compCyc > startCyc, 1'h1)
    `CHK((sampCyc - startCyc > ds - tp) && (sampCyc - startCyc <= ds + 1), 1'h1)
    if (cnt) begin
      first = cyc;
      drops = 0;
      i = 0;
      tick;
      while (resultValid !== 1'h1 && i < 5000) begin
        tick;
        i++;
        drops += (discardPulse === 1'h1);
      end
      `CHK(cyc - first, SCS_PERIOD[rc] * tp)
      `CHK(drops, 0)
      reqStop = 1'h1;
      tick;
      reqStop = 1'h0;
    end
    repeat (3) tick;
    `CHK(busy, 1'h0)
    $display("test done at %0t", $time);
  endtask
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    #1 srst = 1'h0;
    `CHK(3 * SCS_PERIOD[0] + 65, 20'h4b041)
    `CHK(3 * SCS_PERIOD[13] + 40, 20'h000e8)
    `CHK(3 * SCS_PERIOD[6] + 65, 20'h03239)
    `CHK(SCS_PERIOD[6], 20'h010a8)
    `CHK(SCS_PERIOD[0], 20'h19000)
    `CHK(SCS_DELAY[SCS_DELAY_RST], 20'h0000e)
    conv(1'h1, 1'h1, 1'h0, 4'hd, 3'h0, 0, 0);
    conv(1'h0, 1'h0, 1'h1, 4'hf, 3'h4, 37, 0);
    conv(1'h0, 1'h0, 1'h0, 4'hd, 3'h0, 0, 2000);
    conv(1'h0, 1'h1, 1'h1, 4'hc, 3'h5, 0, 0);
    slowTick = 1'h1;
    conv(1'h1, 1'h0, 1'h0, 4'hd, 3'h0, 0, 0);
    slowTick = 1'h0;
    for (int k = 0; k < 5; k++) begin
      seed = lfsr(seed);
      conv(seed[5], 1'h0, seed[4], {2'h3, seed[6], seed[0]}, {1'h0, seed[2:1]}, 0, 0);
    end
    complete_run();
  end
  // watchdog cuts a hang short
  initial begin
    #(8 * 95000);
    errors++;
    complete_run();
  end
endmodule // tb_top
